/* File: hdl/charge_supervisor_fsm.sv */
// supervisory state machine of the charger with its ahb-lite registers
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RULE_01] config three bit seven enables autonomous charging
// [RULE_02] autonomous mode stops watchdog, repurposes throttle pin
// [RULE_03] host keeps reverse turbo off in autonomous
// [RULE_04] setpoint writes never clear autonomous enable
// [RULE_05] twelve hours without termination ends autonomous
// [RULE_06] any fault clears autonomous enable bit
// [RULE_07] config seven bits nine:eight pick eoc
// [RULE_08] entry needs fet on, low battery 1ms
// [RULE_09] autonomous charge uses current setpoint register
// [RULE_10] throttle pin pulled low while autonomous
// [RULE_11] low current in cv for 20/200ms terminates
// [RULE_12] host mode never terminates; host restarts charge
// [RULE_13] watchdog disabled: fault holds until bit cleared
// [RULE_14] no setpoint write in period: fet off
// [RULE_15] timeout keeps current setpoint, regulates system
// [RULE_16] host rewrites a setpoint after timeout
// [RULE_17] config zero bit seven disables watchdog
// [RULE_18] reverse needs battery absent pin low
// [RULE_19] two bits select thermistor profile
// [RULE_20] learn entry: host command, narrow dc only
// [RULE_21] learn exit: command, low battery, absent rise
// [RULE_22] battery above 2.7V, adapter low: battery only
// [RULE_23] reverse needs battery above 5.2V
// [RULE_24] safety timer runs only inside autonomous charging
module charge_supervisor_fsm #(
	parameter int TICK_CYCLES = charge_sup_pkg::CLK_HZ
		/ charge_sup_pkg::TICK_HZ,
	parameter int TICKS_PER_S = charge_sup_pkg::TICK_HZ,
	parameter int SAFETY_TICKS = charge_sup_pkg::SAFETY_HOURS
		* charge_sup_pkg::SECONDS_PER_HOUR * charge_sup_pkg::TICK_HZ
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite register slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// comparators and pins, asynchronous
	input wire charge_sup_pkg::sense_type sense,
	// power stage controls
	output var charge_sup_pkg::drive_type drive,
	// open-drain throttle alert
	output logic throttle_alert_n_o,
	output logic throttle_alert_n_oe
);
	// ----------------------------------------------------------------
	// derived counts
	// ----------------------------------------------------------------
	localparam int ENTRY_CYCLES = TICK_CYCLES
		* charge_sup_pkg::ENTRY_DEBOUNCE_MS * charge_sup_pkg::TICK_HZ
		/ charge_sup_pkg::MS_PER_S;
	localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
	localparam logic [14:0] ENTRY_LAST = 15'(ENTRY_CYCLES - 1);
	localparam logic [7:0] TERM_SHORT = 8'(charge_sup_pkg::TERM_SHORT_MS
		* charge_sup_pkg::TICK_HZ / charge_sup_pkg::MS_PER_S);
	localparam logic [7:0] TERM_LONG = 8'(charge_sup_pkg::TERM_LONG_MS
		* charge_sup_pkg::TICK_HZ / charge_sup_pkg::MS_PER_S);
	localparam logic [17:0] WD_00 = 18'(charge_sup_pkg::WDOG_S_00
		* TICKS_PER_S);
	localparam logic [17:0] WD_01 = 18'(charge_sup_pkg::WDOG_S_01
		* TICKS_PER_S);
	localparam logic [17:0] WD_10 = 18'(charge_sup_pkg::WDOG_S_10
		* TICKS_PER_S);
	localparam logic [17:0] WD_11 = 18'(charge_sup_pkg::WDOG_S_11
		* TICKS_PER_S);
	localparam logic [25:0] SAFETY_LIM = 26'(SAFETY_TICKS);
	localparam int SW = $bits(charge_sup_pkg::sense_type);

	if (TICK_CYCLES < 2 || TICK_CYCLES > 32767 || TICKS_PER_S < 1
		|| charge_sup_pkg::WDOG_S_00 * TICKS_PER_S > 262143
		|| SAFETY_TICKS < 1 || SAFETY_TICKS > 67108863
		|| ENTRY_CYCLES < 1) begin : g_bad_param
		$error("charge_supervisor_fsm: parameter out of range");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	charge_sup_pkg::state_type st_q;
	charge_sup_pkg::state_type st_d;
	charge_sup_pkg::status_type stat;
	logic acc;
	logic host_wr;
	logic host_kick;
	logic [31:0] rd;
	logic auto_en;
	logic fault;
	logic batt_only;
	logic abs_rise;
	logic wd_on;
	logic wd_fire;
	logic [17:0] wd_lim;
	logic [7:0] term_lim;
	logic chg_ok;
	logic deb_cond;
	logic deb_go;
	logic term_cond;
	logic term_go;
	logic safe_go;
	logic charging;

	always_comb begin
		st_d = st_q;
		auto_en = st_q.cfg3[charge_sup_pkg::CFG3_AUTO_EN];
		fault = st_q.sv.fault_detect;
		batt_only = st_q.sv.vbat_above_2v7 && st_q.sv.vadp_below_3v2;
		abs_rise = st_q.sv.battery_absent_pin && !st_q.absent_prev;
		acc = hsel && htrans[1] && hsize == 3'h2;
		host_wr = st_q.dp_sel && st_q.dp_write;
		host_kick = host_wr && (st_q.dp_idx == charge_sup_pkg::IDX_CHG_CUR
			|| st_q.dp_idx == charge_sup_pkg::IDX_VOLT_LIM);
		// autonomous mode owns termination, so the watchdog stands down
		wd_on = !st_q.cfg0[charge_sup_pkg::CFG0_WDOG_DIS] && !auto_en; // see [RULE_02] see [RULE_17]
		case (st_q.cfg3[charge_sup_pkg::CFG3_WDOG_SEL +: 2])
			2'h0: wd_lim = WD_00;
			2'h1: wd_lim = WD_01;
			2'h2: wd_lim = WD_10;
			default: wd_lim = WD_11;
		endcase
		wd_fire = wd_on && st_q.tick && !st_q.wd_expired
			&& st_q.wd_cnt == wd_lim;
		term_lim = st_q.cfg3[charge_sup_pkg::CFG3_TERM_SEL] ? TERM_LONG
			: TERM_SHORT; // see [RULE_11]
		// stop charging in the expiry cycle itself, not one cycle late
		chg_ok = st_q.chg_cur != 16'h0000 && st_q.trickle_v != 16'h0000
			&& !st_q.wd_expired && !wd_fire; // see [RULE_15]
		deb_cond = auto_en && st_q.mode != charge_sup_pkg::M_AUTO
			&& st_q.drv.battery_fet_gate && st_q.sv.vbat_below_entry;
		deb_go = deb_cond && st_q.deb_cnt == ENTRY_LAST; // see [RULE_08]
		term_cond = st_q.mode == charge_sup_pkg::M_AUTO
			&& st_q.sv.ichg_below_eoc && st_q.sv.constant_voltage_phase;
		term_go = term_cond && st_q.tick && st_q.term_cnt == term_lim;
		safe_go = st_q.mode == charge_sup_pkg::M_AUTO && st_q.tick
			&& st_q.safe_cnt == SAFETY_LIM; // see [RULE_05]
		stat = '0;
		stat.mode = st_q.mode;
		stat.learn = st_q.learn;
		stat.wd_expired = st_q.wd_expired;
		stat.battery_only = st_q.drv.battery_only;
		stat.autonomous = st_q.drv.autonomous_active;
		stat.profile = st_q.drv.thermal_charge_profile;
		case (st_q.dp_idx)
			charge_sup_pkg::IDX_CHG_CUR: rd = {16'h0000, st_q.chg_cur};
			charge_sup_pkg::IDX_VOLT_LIM: rd = {16'h0000, st_q.volt_lim};
			charge_sup_pkg::IDX_TRICKLE: rd = {16'h0000, st_q.trickle_v};
			charge_sup_pkg::IDX_CFG0: rd = {16'h0000, st_q.cfg0};
			charge_sup_pkg::IDX_CFG1: rd = {16'h0000, st_q.cfg1};
			charge_sup_pkg::IDX_CFG2: rd = {16'h0000, st_q.cfg2};
			charge_sup_pkg::IDX_CFG3: rd = {16'h0000, st_q.cfg3};
			charge_sup_pkg::IDX_CFG4: rd = {16'h0000, st_q.cfg4};
			charge_sup_pkg::IDX_CFG7: rd = {16'h0000, st_q.cfg7};
			charge_sup_pkg::IDX_STATUS: rd = stat;
			default: rd = 32'h0000_0000;
		endcase

		// ------------------------------------------------------------
		// input synchronisers and 1 ms tick
		// ------------------------------------------------------------
		st_d.s1 = sense;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < SW; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.sv[i] = st_q.s3[i];
			end
		end
		st_d.tick = st_q.tick_cnt == TICK_LAST;
		st_d.tick_cnt = st_d.tick ? 15'h0000 : st_q.tick_cnt + 15'h0001;

		// ------------------------------------------------------------
		// bus: writes in the data phase, reads take one wait state
		// ------------------------------------------------------------
		if (st_q.dp_wait) begin
			st_d.dp_wait = 1'b0;
			st_d.rdata = rd;
		end
		if (host_wr) begin
			// no side effect on cfg3, so setpoint writes keep auto on
			case (st_q.dp_idx)
				charge_sup_pkg::IDX_CHG_CUR: st_d.chg_cur = hwdata[15:0]; // see [RULE_04]
				charge_sup_pkg::IDX_VOLT_LIM: st_d.volt_lim = hwdata[15:0]; // see [RULE_04]
				charge_sup_pkg::IDX_TRICKLE: st_d.trickle_v = hwdata[15:0];
				charge_sup_pkg::IDX_CFG0: st_d.cfg0 = hwdata[15:0];
				charge_sup_pkg::IDX_CFG1: st_d.cfg1 = hwdata[15:0];
				charge_sup_pkg::IDX_CFG2: st_d.cfg2 = hwdata[15:0];
				charge_sup_pkg::IDX_CFG3: st_d.cfg3 = hwdata[15:0]; // see [RULE_01]
				charge_sup_pkg::IDX_CFG4: st_d.cfg4 = hwdata[15:0];
				charge_sup_pkg::IDX_CFG7: st_d.cfg7 = hwdata[15:0];
				default: ;
			endcase
		end
		if (hready) begin
			st_d.dp_sel = acc;
			st_d.dp_write = hwrite;
			st_d.dp_wait = acc && !hwrite;
			st_d.dp_idx = haddr[31:10] == 22'h00_0000 ? haddr[9:2]
				: charge_sup_pkg::IDX_NONE;
		end

		// ------------------------------------------------------------
		// watchdog: expiry wins over a same-cycle setpoint write
		// ------------------------------------------------------------
		if (wd_fire) begin
			st_d.wd_expired = 1'b1; // see [RULE_14] see [RULE_15]
			st_d.wd_cnt = 18'h0_0000;
		end else if (host_kick) begin
			st_d.wd_expired = 1'b0; // see [RULE_16]
			st_d.wd_cnt = 18'h0_0000;
		end else if (!wd_on) begin
			st_d.wd_cnt = 18'h0_0000;
		end else if (st_q.tick && !st_q.wd_expired) begin
			st_d.wd_cnt = st_q.wd_cnt + 18'h0_0001;
		end

		// ------------------------------------------------------------
		// battery learn mode
		// ------------------------------------------------------------
		st_d.absent_prev = st_q.sv.battery_absent_pin;
		if (st_q.learn) begin
			if (!st_d.cfg1[charge_sup_pkg::CFG1_LEARN_REQ] || abs_rise
				|| (st_q.cfg1[charge_sup_pkg::CFG1_LEARN_VEXIT]
				&& st_q.sv.vbat_below_trickle)) begin
				st_d.learn = 1'b0; // see [RULE_21]
				st_d.cfg1[charge_sup_pkg::CFG1_LEARN_REQ] = 1'b0;
			end
		end else if (st_q.cfg1[charge_sup_pkg::CFG1_LEARN_REQ]
			&& st_q.sv.narrow_dc_operation) begin
			st_d.learn = 1'b1; // see [RULE_20]
		end

		// ------------------------------------------------------------
		// charge mode machine and its timers
		// ------------------------------------------------------------
		st_d.deb_cnt = deb_cond && !deb_go ? st_q.deb_cnt + 15'h0001
			: 15'h0000;
		if (!term_cond) begin
			st_d.term_cnt = 8'h00;
		end else if (st_q.tick) begin
			st_d.term_cnt = st_q.term_cnt + 8'h01;
		end
		if (st_q.mode == charge_sup_pkg::M_AUTO && st_q.tick) begin
			st_d.safe_cnt = st_q.safe_cnt + 26'h000_0001;
		end
		case (st_q.mode)
			charge_sup_pkg::M_IDLE: begin
				if (fault) begin
					st_d.mode = charge_sup_pkg::M_FAULT;
				end else if (deb_go) begin
					st_d.mode = charge_sup_pkg::M_AUTO; // see [RULE_08]
				end else if (!auto_en && chg_ok) begin
					st_d.mode = charge_sup_pkg::M_HOST;
				end
			end
			charge_sup_pkg::M_HOST: begin
				// host mode holds cv with small current, never ends itself
				if (fault) begin
					st_d.mode = charge_sup_pkg::M_FAULT;
				end else if (auto_en || !chg_ok) begin
					st_d.mode = charge_sup_pkg::M_IDLE; // see [RULE_12]
				end
			end
			charge_sup_pkg::M_AUTO: begin
				if (fault) begin
					st_d.mode = charge_sup_pkg::M_FAULT;
				end else if (!auto_en || safe_go || term_go) begin
					st_d.mode = charge_sup_pkg::M_IDLE; // see [RULE_11]
				end
				if (safe_go) begin
					st_d.cfg3[charge_sup_pkg::CFG3_AUTO_EN] = 1'b0; // see [RULE_05]
				end
			end
			charge_sup_pkg::M_FAULT: begin
				if (!fault && !st_q.cfg0[charge_sup_pkg::CFG0_WDOG_DIS]) begin
					st_d.mode = charge_sup_pkg::M_IDLE; // see [RULE_13]
				end
			end
			default: st_d.mode = charge_sup_pkg::M_IDLE;
		endcase
		if (fault) begin
			st_d.cfg3[charge_sup_pkg::CFG3_AUTO_EN] = 1'b0; // see [RULE_06]
		end
		if (st_d.mode != charge_sup_pkg::M_AUTO) begin
			st_d.safe_cnt = 26'h000_0000; // see [RULE_24]
		end

		// ------------------------------------------------------------
		// outputs
		// ------------------------------------------------------------
		charging = st_d.mode == charge_sup_pkg::M_HOST
			|| st_d.mode == charge_sup_pkg::M_AUTO;
		st_d.drv.battery_only = batt_only;
		st_d.drv.learn_active = st_d.learn;
		st_d.drv.autonomous_active = st_d.mode == charge_sup_pkg::M_AUTO;
		st_d.drv.battery_fet_gate = batt_only || st_d.learn
			|| (!st_d.wd_expired && st_d.mode != charge_sup_pkg::M_FAULT
			&& !st_q.sv.battery_absent_pin); // see [RULE_14] see [RULE_22]
		st_d.drv.adapter_fet_gate = batt_only
			|| !st_q.sv.vadp_below_3v2; // see [RULE_22]
		st_d.drv.switcher_enable = !st_d.learn && !batt_only
			&& st_d.volt_lim != 16'h0000; // see [RULE_20] see [RULE_15]
		st_d.drv.charge_enable = charging;
		st_d.drv.constant_voltage_phase = charging
			&& st_q.sv.constant_voltage_phase; // see [RULE_12]
		st_d.drv.charge_current_target = st_d.chg_cur; // see [RULE_09]
		st_d.drv.reverse_enable = st_d.cfg1[charge_sup_pkg::CFG1_REVERSE_EN]
			&& !st_q.sv.battery_absent_pin // see [RULE_18]
			&& st_q.sv.vbat_above_5v2; // see [RULE_23]
		st_d.drv.thermal_charge_profile = {
			st_d.cfg2[charge_sup_pkg::CFG2_PROFILE_HI],
			st_d.cfg4[charge_sup_pkg::CFG4_PROFILE_LO]}; // see [RULE_19]
		st_d.drv.thermistor_source_on =
			|st_d.drv.thermal_charge_profile; // see [RULE_19]
		st_d.drv.eoc_select =
			st_d.cfg7[charge_sup_pkg::CFG7_EOC_SEL +: 2]; // see [RULE_07]
		st_d.throttle_oe = st_d.cfg3[charge_sup_pkg::CFG3_AUTO_EN]
			? st_d.mode == charge_sup_pkg::M_AUTO // see [RULE_10] see [RULE_02]
			: st_q.sv.throttle_request;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
			st_q.mode <= charge_sup_pkg::M_IDLE;
			st_q.chg_cur <= charge_sup_pkg::REG_RESET;
			st_q.volt_lim <= charge_sup_pkg::REG_RESET;
			st_q.cfg3 <= charge_sup_pkg::REG_RESET;
			st_q.dp_idx <= charge_sup_pkg::IDX_NONE;
		end else begin
			st_q <= st_d;
		end
	end

	assign hreadyout = !st_q.dp_wait;
	assign hresp = 1'b0;
	assign hrdata = st_q.rdata;
	assign drive = st_q.drv;
	assign throttle_alert_n_o = 1'b0;
	assign throttle_alert_n_oe = st_q.throttle_oe;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	auto_no_wdog_a: assert property ( // see [RULE_02]
		$past(auto_en) && !$past(host_kick) |-> !$rose(st_q.wd_expired))
		else $error("watchdog expired while autonomous enabled");
	fault_clear_a: assert property ( // see [RULE_06]
		fault |=> !st_q.cfg3[charge_sup_pkg::CFG3_AUTO_EN]
			&& st_q.mode == charge_sup_pkg::M_FAULT)
		else $error("fault kept autonomous enable");
	safety_stop_a: assert property ( // see [RULE_05]
		safe_go && !fault |=> !st_q.cfg3[charge_sup_pkg::CFG3_AUTO_EN]
			&& st_q.mode == charge_sup_pkg::M_IDLE && !drive.charge_enable)
		else $error("safety limit did not end autonomous charging");
	safe_idle_a: assert property ( // see [RULE_24]
		st_q.mode != charge_sup_pkg::M_AUTO |-> st_q.safe_cnt == 26'h000_0000)
		else $error("safety timer running outside autonomous");
	throttle_ind_a: assert property ( // see [RULE_10]
		st_q.cfg3[charge_sup_pkg::CFG3_AUTO_EN] |-> throttle_alert_n_oe
			== (st_q.mode == charge_sup_pkg::M_AUTO) && !throttle_alert_n_o)
		else $error("throttle pin not tracking autonomous charging");
	entry_debounce_a: assert property ( // see [RULE_08]
		$rose(st_q.mode == charge_sup_pkg::M_AUTO) |->
			$past(st_q.deb_cnt) == ENTRY_LAST && $past(deb_cond))
		else $error("autonomous entry without debounce");
	term_time_a: assert property ( // see [RULE_11]
		term_go && !fault && !safe_go ##1 auto_en |->
			$past(st_q.term_cnt) == $past(term_lim)
			&& st_q.mode == charge_sup_pkg::M_IDLE)
		else $error("termination time wrong");
	wdog_period_a: assert property ( // see [RULE_14]
		$rose(st_q.wd_expired) && !st_q.drv.battery_only && !st_q.learn |->
			!drive.battery_fet_gate && $past(st_q.wd_cnt) == $past(wd_lim))
		else $error("watchdog period or fet shutdown wrong");
	wdog_keep_a: assert property ( // see [RULE_15]
		$rose(st_q.wd_expired) && !$past(host_wr) |->
			$stable(st_q.chg_cur) && !drive.charge_enable)
		else $error("timeout altered setpoint or kept charging");
	fault_hold_a: assert property ( // see [RULE_13]
		st_q.mode == charge_sup_pkg::M_FAULT
			&& st_q.cfg0[charge_sup_pkg::CFG0_WDOG_DIS]
			|=> st_q.mode == charge_sup_pkg::M_FAULT)
		else $error("fault left with watchdog disabled");
	reverse_gate_a: assert property ( // see [RULE_18]
		drive.reverse_enable |-> $past(!st_q.sv.battery_absent_pin
			&& st_q.sv.vbat_above_5v2))
		else $error("reverse enabled against gating");
	learn_entry_a: assert property ( // see [RULE_20]
		$rose(st_q.learn) |-> $past(st_q.sv.narrow_dc_operation)
			&& !drive.switcher_enable)
		else $error("learn entered outside narrow dc");
	learn_exit_a: assert property ( // see [RULE_21]
		st_q.learn && abs_rise |=> !st_q.learn && (drive.switcher_enable
			|| $past(batt_only) || st_q.volt_lim == 16'h0000))
		else $error("learn kept after battery removal");
	batt_only_a: assert property ( // see [RULE_22]
		$past(batt_only) |-> drive.battery_fet_gate
			&& drive.adapter_fet_gate && !drive.switcher_enable)
		else $error("battery only gates wrong");

	auto_entry_c: cover property (
		$rose(st_q.mode == charge_sup_pkg::M_AUTO));
	auto_term_c: cover property (term_go ##1 auto_en);
	wdog_fire_c: cover property (wd_fire ##[1:20] host_kick);
	learn_cycle_c: cover property ($rose(st_q.learn) ##[1:50] !st_q.learn);
endmodule

`default_nettype wire

/* File: hdl/charge_sup_pkg.sv */
// constants and carrier types of the charge supervisor
package charge_sup_pkg;
	// ----------------------------------------------------------------
	// timing, each figure in its own unit
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_HZ = 1_000;
	localparam int ENTRY_DEBOUNCE_MS = 1;
	localparam int TERM_SHORT_MS = 20;
	localparam int TERM_LONG_MS = 200;
	localparam int SAFETY_HOURS = 12;
	localparam int SECONDS_PER_HOUR = 3_600;
	localparam int MS_PER_S = 1_000;
	localparam int WDOG_S_00 = 175;
	localparam int WDOG_S_01 = 88;
	localparam int WDOG_S_10 = 44;
	localparam int WDOG_S_11 = 22;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CHG_CUR = 8'h14;
	localparam logic [7:0] IDX_VOLT_LIM = 8'h15;
	localparam logic [7:0] IDX_CFG0 = 8'h39;
	localparam logic [7:0] IDX_CFG2 = 8'h3b;
	localparam logic [7:0] IDX_CFG1 = 8'h3c;
	localparam logic [7:0] IDX_TRICKLE = 8'h3e;
	localparam logic [7:0] IDX_CFG3 = 8'h4c;
	localparam logic [7:0] IDX_CFG4 = 8'h4e;
	localparam logic [7:0] IDX_CFG7 = 8'h52;
	localparam logic [7:0] IDX_STATUS = 8'h60;
	localparam logic [7:0] IDX_NONE = 8'hff;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG0_WDOG_DIS = 7;
	localparam int CFG1_REVERSE_EN = 11;
	localparam int CFG1_LEARN_REQ = 12;
	localparam int CFG1_LEARN_VEXIT = 13;
	localparam int CFG2_PROFILE_HI = 5;
	localparam int CFG3_AUTO_EN = 7;
	localparam int CFG3_WDOG_SEL = 11;
	localparam int CFG3_TERM_SEL = 13;
	localparam int CFG4_PROFILE_LO = 14;
	localparam int CFG7_EOC_SEL = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_HOST = 2'h1,
		M_AUTO = 2'h3,
		M_FAULT = 2'h2
	} mode_type;

	typedef struct packed {
		logic battery_absent_pin;
		logic vbat_below_entry;
		logic ichg_below_eoc;
		logic constant_voltage_phase;
		logic vbat_above_2v7;
		logic vadp_below_3v2;
		logic vbat_above_5v2;
		logic vbat_below_trickle;
		logic fault_detect;
		logic narrow_dc_operation;
		logic throttle_request;
	} sense_type;

	typedef struct packed {
		logic battery_fet_gate;
		logic adapter_fet_gate;
		logic switcher_enable;
		logic charge_enable;
		logic reverse_enable;
		logic thermistor_source_on;
		logic [1:0] thermal_charge_profile;
		logic [1:0] eoc_select;
		logic battery_only;
		logic learn_active;
		logic autonomous_active;
		logic constant_voltage_phase;
		logic [15:0] charge_current_target;
	} drive_type;

	typedef struct packed {
		logic [23:0] reserved;
		logic [1:0] profile;
		logic autonomous;
		logic battery_only;
		logic wd_expired;
		logic learn;
		mode_type mode;
	} status_type;

	typedef struct packed {
		mode_type mode;
		logic [15:0] chg_cur;
		logic [15:0] volt_lim;
		logic [15:0] trickle_v;
		logic [15:0] cfg0;
		logic [15:0] cfg1;
		logic [15:0] cfg2;
		logic [15:0] cfg3;
		logic [15:0] cfg4;
		logic [15:0] cfg7;
		logic dp_sel;
		logic dp_write;
		logic dp_wait;
		logic [7:0] dp_idx;
		logic [31:0] rdata;
		sense_type s1;
		sense_type s2;
		sense_type s3;
		sense_type sv;
		logic [14:0] tick_cnt;
		logic tick;
		logic [14:0] deb_cnt;
		logic [7:0] term_cnt;
		logic [17:0] wd_cnt;
		logic [25:0] safe_cnt;
		logic wd_expired;
		logic learn;
		logic absent_prev;
		drive_type drv;
		logic throttle_oe;
	} state_type;
endpackage

/* File: bench/host_model.sv */
// host side model: ahb-lite master doing single word transfers
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock and slave answer
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// master request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
	end
	// byte address is four times the index; no wait count assumed
	task automatic xfer(input logic [7:0] idx, input logic wr,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h00_0000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: bench/test_charge_supervisor_fsm.sv */
// self-checking bench of the charge supervisor
`timescale 1ns/1ps
`default_nettype none
module test_charge_supervisor_fsm;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, od, oe;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	charge_sup_pkg::sense_type sense = '0;
	charge_sup_pkg::drive_type drive;
	int errors = 0;
	int check_count = 0;
	int i;
	// pulled-up open-drain pin
	wire logic pin_n = oe ? od : 1'b1;
	wire logic [3:0] gates = {drive.battery_fet_gate, drive.adapter_fet_gate,
		drive.switcher_enable, drive.battery_only};
	wire logic [1:0] lrn = {drive.learn_active, drive.switcher_enable};
	always #20 hclk = ~hclk;
	charge_supervisor_fsm #(.TICK_CYCLES(10), .TICKS_PER_S(2),
		.SAFETY_TICKS(50)) u_charge_supervisor_fsm (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense),
		.drive(drive), .throttle_alert_n_o(od), .throttle_alert_n_oe(oe));
	host_model u_host_model (.hclk(hclk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	task automatic chk(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		u_host_model.xfer(idx, 1'b1, d, rv);
	endtask
	task automatic rd(input logic [7:0] idx);
		u_host_model.xfer(idx, 1'b0, '0, rv);
	endtask
	// bounded, since the tick divider makes every delay long
	task automatic wait_auto(input logic v);
		for (i = 0; i < 2000 && drive.autonomous_active !== v; i++) @(posedge hclk);
	endtask
	task automatic t_select;
		for (int k = 0; k < 4; k++) begin
			wr(charge_sup_pkg::IDX_CFG7, 32'(k) << 8);
			wr(charge_sup_pkg::IDX_CFG2, 32'(k / 2) << 5);
			wr(charge_sup_pkg::IDX_CFG4, 32'(k % 2) << 14);
			repeat (3) @(posedge hclk);
			chk("eoc", 32'(drive.eoc_select), 32'(k));
			chk("prof", 32'(drive.thermal_charge_profile), 32'(k));
			chk("src", 32'(drive.thermistor_source_on), 32'(k != 0));
		end
		rd(charge_sup_pkg::IDX_CFG7);
		chk("cfg7", rv, 32'h0000_0300);
		rd(charge_sup_pkg::IDX_NONE);
		chk("unmapped", rv, '0);
	endtask
	task automatic t_auto;
		wr(charge_sup_pkg::IDX_TRICKLE, 32'h0000_0100);
		wr(charge_sup_pkg::IDX_VOLT_LIM, 32'h0000_1000);
		wr(charge_sup_pkg::IDX_CHG_CUR, 32'h0000_0200);
		// reverse request stays clear while auto is on
		wr(charge_sup_pkg::IDX_CFG3, 32'h0000_0080);
		sense.vbat_below_entry <= 1'b1;
		wait_auto(1'b1);
		chk("auto", 32'(drive.autonomous_active), 32'h1);
		chk("target", 32'(drive.charge_current_target), 32'h200);
		chk("alert", 32'(pin_n), 32'h0);
		wr(charge_sup_pkg::IDX_CHG_CUR, 32'h0000_0200);
		rd(charge_sup_pkg::IDX_CFG3);
		chk("keep en", 32'(rv[7]), 32'h1);
		sense.vbat_below_entry <= 1'b0;
		sense.ichg_below_eoc <= 1'b1;
		sense.constant_voltage_phase <= 1'b1;
		wait_auto(1'b0);
		chk("term", 32'(drive.autonomous_active), 32'h0);
		sense.ichg_below_eoc <= 1'b0;
		sense.vbat_below_entry <= 1'b1;
		wait_auto(1'b1);
		wait_auto(1'b0);
		rd(charge_sup_pkg::IDX_CFG3);
		chk("safety", 32'(rv[7]), 32'h0);
	endtask
	task automatic t_fault;
		wr(charge_sup_pkg::IDX_CFG3, 32'h0000_0080);
		wait_auto(1'b1);
		sense.fault_detect <= 1'b1;
		wait_auto(1'b0);
		rd(charge_sup_pkg::IDX_CFG3);
		chk("fault", 32'(rv[7]), 32'h0);
		wr(charge_sup_pkg::IDX_CFG0, 32'h0000_0080);
		sense.fault_detect <= 1'b0;
		repeat (6) @(posedge hclk);
		rd(charge_sup_pkg::IDX_STATUS);
		chk("hold", 32'(rv[1:0]), 32'(charge_sup_pkg::M_FAULT));
		wr(charge_sup_pkg::IDX_CFG0, 32'h0000_0000);
		repeat (3) @(posedge hclk);
		rd(charge_sup_pkg::IDX_STATUS);
		chk("resume", 32'(rv[1:0]), 32'(charge_sup_pkg::M_HOST));
	endtask
	task automatic t_wdog;
		wr(charge_sup_pkg::IDX_CFG3, 32'h0000_1800);
		wr(charge_sup_pkg::IDX_CHG_CUR, 32'h0000_0200);
		for (i = 0; i < 2000 && drive.battery_fet_gate !== 1'b0; i++) @(posedge hclk);
		chk("stop", 32'(drive.charge_enable), 32'h0);
		rd(charge_sup_pkg::IDX_STATUS);
		chk("expired", 32'(rv[3]), 32'h1);
		rd(charge_sup_pkg::IDX_CHG_CUR);
		chk("kept", rv, 32'h0000_0200);
		wr(charge_sup_pkg::IDX_CHG_CUR, 32'h0000_0200);
		rd(charge_sup_pkg::IDX_STATUS);
		chk("rearm", 32'(rv[3]), 32'h0);
	endtask
	task automatic t_reverse;
		sense.vbat_above_5v2 <= 1'b1;
		sense.battery_absent_pin <= 1'b1;
		wr(charge_sup_pkg::IDX_CFG1, 32'h0000_0800);
		repeat (6) @(posedge hclk);
		chk("rev absent", 32'(drive.reverse_enable), 32'h0);
		sense.battery_absent_pin <= 1'b0;
		repeat (6) @(posedge hclk);
		chk("rev on", 32'(drive.reverse_enable), 32'h1);
		sense.vbat_above_5v2 <= 1'b0;
		repeat (6) @(posedge hclk);
		chk("rev low", 32'(drive.reverse_enable), 32'h0);
	endtask
	// one learn entry per exit path: battery removal, low battery, command
	task automatic t_learn;
		sense.narrow_dc_operation <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			sense.battery_absent_pin <= 1'b0;
			sense.vbat_below_trickle <= 1'b0;
			wr(charge_sup_pkg::IDX_CFG1, 32'h0000_3000);
			repeat (6) @(posedge hclk);
			chk("learn", 32'(lrn), 32'h2);
			if (k == 0) sense.battery_absent_pin <= 1'b1;
			if (k == 1) sense.vbat_below_trickle <= 1'b1;
			if (k == 2) wr(charge_sup_pkg::IDX_CFG1, 32'h0000_0000);
			repeat (6) @(posedge hclk);
			chk("unlearn", 32'(lrn), 32'h1);
		end
	endtask
	task automatic t_batt;
		chk("no alert", 32'(pin_n), 32'h1);
		sense.vbat_above_2v7 <= 1'b1;
		sense.vadp_below_3v2 <= 1'b1;
		sense.throttle_request <= 1'b1;
		repeat (6) @(posedge hclk);
		chk("batt only", 32'(gates), 32'hd);
		chk("throttle", 32'(pin_n), 32'h0);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#2_000_000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_select();
		t_auto();
		t_fault();
		t_wdog();
		t_reverse();
		t_learn();
		t_batt();
		print_verdict();
	end
endmodule
`default_nettype wire
